// ### psm_pkg.sv
// package for the pipelined signed multiplier: bus map, config layout, widths
// assumes a 32-bit AHB-Lite bus and a single 20 MHz clock
package psm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int OPW = 18;
  localparam int PRW = 36;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_PROD_LO = 8'h04;
  localparam logic [7:0] ADDR_PROD_HI = 8'h08;
  localparam logic [7:0] ADDR_CHAIN = 8'h0C;

  // ----------------------------------------------------------------
  // config register layout, bit 9 first
  // ----------------------------------------------------------------
  localparam int CFG_W = 10;
  localparam int CFG_LSB = 0;
  localparam int PROD_HI_W = PRW - 32;

  typedef struct packed {
    logic inv_pclr;   // bit 9
    logic inv_pen;    // bit 8
    logic inv_bclr;   // bit 7
    logic inv_ben;    // bit 6
    logic inv_aclr;   // bit 5
    logic inv_aen;    // bit 4
    logic b_cascade;  // bit 3: 0 direct input, 1 chain input
    logic p_ins;      // bit 2
    logic b_ins;      // bit 1
    logic a_ins;      // bit 0
  } psm_cfg_t;

  // all three stages inserted, direct source, no inversion
  localparam logic [CFG_W-1:0] CFG_RST = 10'h007;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------
  // clock figures
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;

endpackage : psm_pkg

// ### psm_stage.sv
// one optional pipeline stage with enable and synchronous clear
// assumes static insert setting; no asynchronous reset in the data path
`timescale 1ns/10ps
module psm_stage #(
  parameter int WIDTH = 18
) (
  // clock
  input wire logic clk,
  // static settings
  input wire logic ins,
  input wire logic en_inv,
  input wire logic clr_inv,
  // controls and data
  input wire logic en,
  input wire logic clr,
  input wire logic [WIDTH-1:0] d,
  // stage output
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage_r;

  // clear beats enable, both after polarity selection
  always_ff @(posedge clk)
  begin
    if (clr ^ clr_inv)
    begin
      stage_r <= '0;
    end
    else if (en ^ en_inv)
    begin
      stage_r <= d;
    end
  end

  // insert or bypass
  always_comb
  begin
    q = ins ? stage_r : d;
  end

endmodule : psm_stage

// ### psm_mult_top.sv
// signed 18x18 multiplier with three optional stages and an AHB-Lite config port
// assumes user logic drives operands and stage controls synchronous to hclk
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module psm_mult_top #(
  parameter bit CLK_INVERT = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // operands
  input wire logic [psm_pkg::OPW-1:0] operand_a,
  input wire logic [psm_pkg::OPW-1:0] operand_b,
  input wire logic [psm_pkg::OPW-1:0] operand_chain_in,
  // stage controls
  input wire logic first_stage_enable,
  input wire logic first_stage_clear,
  input wire logic second_stage_enable,
  input wire logic second_stage_clear,
  input wire logic product_stage_enable,
  input wire logic product_stage_clear,
  // results
  output logic [psm_pkg::PRW-1:0] product,
  output logic [psm_pkg::OPW-1:0] operand_chain_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  psm_pkg::psm_cfg_t cfg_r;
  logic stage_clk;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_take;
  logic cfg_wr_now;
  logic [psm_pkg::OPW-1:0] b_sel;
  logic [psm_pkg::OPW-1:0] a_q;
  logic [psm_pkg::OPW-1:0] b_q;
  logic [psm_pkg::PRW-1:0] p_raw;
  logic [psm_pkg::PRW-1:0] p_q;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------

  // address phase accepted
  assign addr_take = hsel && hready && (htrans == psm_pkg::HTRANS_NONSEQ);
  assign cfg_wr_now = wr_pend_r && (wr_addr_r == psm_pkg::ADDR_CFG);

  // zero-wait, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= psm_pkg::HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= psm_pkg::HRESP_OKAY;
    end
  end

  // pending write capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_take && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // static configuration register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r <= psm_pkg::psm_cfg_t'(psm_pkg::CFG_RST);
    end
    else if (cfg_wr_now)
    begin
      cfg_r <= psm_pkg::psm_cfg_t'(hwdata[psm_pkg::CFG_W-1:psm_pkg::CFG_LSB]);
    end
  end

  // read selection, unmapped reads zero
  always_comb
  begin
    case (haddr[7:0])
      psm_pkg::ADDR_CFG: rd_mux = {22'h000000, cfg_r};
      psm_pkg::ADDR_PROD_LO: rd_mux = p_q[31:0];
      psm_pkg::ADDR_PROD_HI: rd_mux = {28'h0000000, p_q[psm_pkg::PRW-1:32]};
      psm_pkg::ADDR_CHAIN: rd_mux = {14'h0000, b_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addr_take && !hwrite)
    begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------

  // shared stage clock with static inversion
  assign stage_clk = hclk ^ CLK_INVERT;

  // second operand source
  assign b_sel = cfg_r.b_cascade ? operand_chain_in : operand_b;

  // first operand stage
  psm_stage #(.WIDTH(psm_pkg::OPW)) u_first_operand_stage (
    .clk(stage_clk),
    .ins(cfg_r.a_ins),
    .en_inv(cfg_r.inv_aen),
    .clr_inv(cfg_r.inv_aclr),
    .en(first_stage_enable),
    .clr(first_stage_clear),
    .d(operand_a),
    .q(a_q)
  );

  // second operand stage
  psm_stage #(.WIDTH(psm_pkg::OPW)) u_second_operand_stage (
    .clk(stage_clk),
    .ins(cfg_r.b_ins),
    .en_inv(cfg_r.inv_ben),
    .clr_inv(cfg_r.inv_bclr),
    .en(second_stage_enable),
    .clr(second_stage_clear),
    .d(b_sel),
    .q(b_q)
  );

  // full signed product
  assign p_raw = $signed(a_q) * $signed(b_q);

  // product stage
  psm_stage #(.WIDTH(psm_pkg::PRW)) u_product_stage (
    .clk(stage_clk),
    .ins(cfg_r.p_ins),
    .en_inv(cfg_r.inv_pen),
    .clr_inv(cfg_r.inv_pclr),
    .en(product_stage_enable),
    .clr(product_stage_clear),
    .d(p_raw),
    .q(p_q)
  );

  // results; chain out is whatever feeds the multiplier
  assign product = p_q;
  assign operand_chain_out = b_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_chain_bypass;
    @(posedge stage_clk) disable iff (!hresetn)
    !cfg_r.b_ins |-> operand_chain_out == (cfg_r.b_cascade ? operand_chain_in : operand_b);
  endproperty
  a_chain_bypass: assert property (p_chain_bypass) else $error("chain out not selected operand");

  property p_chain_hold;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.b_ins && !cfg_wr_now && !(second_stage_enable ^ cfg_r.inv_ben)
      && !(second_stage_clear ^ cfg_r.inv_bclr) |=> $stable(operand_chain_out);
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("chain out moved while held");

  property p_a_load;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.a_ins && !cfg_wr_now && (first_stage_enable ^ cfg_r.inv_aen)
      && !(first_stage_clear ^ cfg_r.inv_aclr) |=> a_q == $past(operand_a);
  endproperty
  a_a_load: assert property (p_a_load) else $error("first stage did not load");

  property p_a_clear;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.a_ins && !cfg_wr_now && (first_stage_clear ^ cfg_r.inv_aclr) |=> a_q == '0;
  endproperty
  a_a_clear: assert property (p_a_clear) else $error("first stage not cleared");

  property p_b_load;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.b_ins && !cfg_wr_now && (second_stage_enable ^ cfg_r.inv_ben)
      && !(second_stage_clear ^ cfg_r.inv_bclr) |=> b_q == $past(b_sel);
  endproperty
  a_b_load: assert property (p_b_load) else $error("second stage did not load");

  property p_b_clear;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.b_ins && !cfg_wr_now && (second_stage_clear ^ cfg_r.inv_bclr) |=> b_q == '0;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("second stage not cleared");

  property p_p_load;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.p_ins && !cfg_wr_now && (product_stage_enable ^ cfg_r.inv_pen)
      && !(product_stage_clear ^ cfg_r.inv_pclr) |=> product == $past(p_raw);
  endproperty
  a_p_load: assert property (p_p_load) else $error("product stage did not load");

  property p_p_clear;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.p_ins && !cfg_wr_now && (product_stage_clear ^ cfg_r.inv_pclr) |=> product == '0;
  endproperty
  a_p_clear: assert property (p_p_clear) else $error("product stage not cleared");

  property p_inv_clear;
    @(posedge stage_clk) disable iff (!hresetn)
    cfg_r.p_ins && cfg_r.inv_pclr && !cfg_wr_now && !product_stage_clear |=> product == '0;
  endproperty
  a_inv_clear: assert property (p_inv_clear) else $error("inverted clear not honoured");

  property p_comb_product;
    @(posedge stage_clk) disable iff (!hresetn)
    !cfg_r.a_ins && !cfg_r.b_ins && !cfg_r.p_ins
      |-> $signed(product) == $signed(operand_a)
        * $signed(cfg_r.b_cascade ? operand_chain_in : operand_b);
  endproperty
  a_comb_product: assert property (p_comb_product) else $error("product wrong");

endmodule : psm_mult_top

// ### psm_nbr_model.sv
// neighbouring multiplier block: its inserted second-operand stage feeds our chain input
// assumes the bench drives its data at rising edges of the shared clock
`timescale 1ns/10ps
module psm_nbr_model (
  // clock
  input wire logic clk,
  // neighbour operand
  input wire logic [psm_pkg::OPW-1:0] d,
  // chained operand toward the next block
  output logic [psm_pkg::OPW-1:0] q
);
  // neighbour stage changes only on rising edges, never between them
  always_ff @(posedge clk)
  begin
    q <= d;
  end
endmodule : psm_nbr_model

// ### testbench.sv
// self-checking bench for the pipelined signed multiplier
// assumes one 20 MHz clock, zero-wait AHB-Lite slave, neighbour model on the chain input
`timescale 1ns/10ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [17:0] op_a, op_b, nbr_d, ch_in, ch_out, ch_out_n;
  logic [5:0] ctl;
  logic [35:0] prod, prod_n;
  int num_errors, n_compared, cyc;

  // one slave: its ready is the bus ready
  assign hready = hreadyout;

  psm_mult_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .operand_a(op_a),
    .operand_b(op_b), .operand_chain_in(ch_in), .first_stage_enable(ctl[5]),
    .first_stage_clear(ctl[4]), .second_stage_enable(ctl[3]),
    .second_stage_clear(ctl[2]), .product_stage_enable(ctl[1]),
    .product_stage_clear(ctl[0]), .product(prod), .operand_chain_out(ch_out));

  psm_nbr_model nbr (.clk(hclk), .d(nbr_d), .q(ch_in));

  // same block with the stage clock inverted: its stages act on falling hclk edges
  psm_mult_top #(.CLK_INVERT(1'b1)) dut_inv (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(), .hresp(), .hrdata(), .operand_a(op_a),
    .operand_b(op_b), .operand_chain_in(ch_in), .first_stage_enable(ctl[5]),
    .first_stage_clear(ctl[4]), .second_stage_enable(ctl[3]),
    .second_stage_clear(ctl[2]), .product_stage_enable(ctl[1]),
    .product_stage_clear(ctl[0]), .product(prod_n), .operand_chain_out(ch_out_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [35:0] mul(input logic [17:0] a, input logic [17:0] b);
    return $signed(a) * $signed(b);
  endfunction : mul

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= psm_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(36'(hresp), 36'(psm_pkg::HRESP_OKAY));
  endtask : bus

  // apply controls and operands at one edge, let the next edge act, settle
  task automatic go(input logic [5:0] c, input logic [17:0] a, input logic [17:0] b);
    @(posedge hclk);
    ctl <= c;
    op_a <= a;
    op_b <= b;
    @(posedge hclk);
    #1;
  endtask : go

  task automatic stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // clock
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {op_a, op_b, nbr_d} = '0;
    // stages have no reset: clears held through reset give them known contents
    ctl = 6'b010101;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, psm_pkg::ADDR_CFG, 32'h0);
    chk(36'(rd), 36'h007);
    bus(1'b0, 8'h10, 32'h0);
    chk(36'(rd), 36'h0);
    // clears with enables low, then operand and product loads
    go(6'b010101, 18'h00005, 18'h00006);
    chk(prod, 36'h0);
    chk(36'(ch_out), 36'h0);
    go(6'b101000, 18'h00003, 18'h3FFFE);
    chk(36'(ch_out), 36'h3FFFE);
    chk(36'(ch_out_n), 36'h3FFFE);
    chk(prod, 36'h0);
    go(6'b000010, 18'h00005, 18'h00007);
    chk(prod, mul(18'h00003, 18'h3FFFE));
    chk(prod_n, mul(18'h00003, 18'h3FFFE));
    chk(36'(ch_out), 36'h3FFFE);
    bus(1'b0, psm_pkg::ADDR_PROD_LO, 32'h0);
    chk(36'(rd), 36'hFFFFFFFA);
    bus(1'b0, psm_pkg::ADDR_PROD_HI, 32'h0);
    chk(36'(rd), 36'h00F);
    bus(1'b0, psm_pkg::ADDR_CHAIN, 32'h0);
    chk(36'(rd), 36'h3FFFE);
    // most negative operands
    go(6'b101010, 18'h20000, 18'h20000);
    go(6'b101010, 18'h20000, 18'h20000);
    chk(prod, 36'h400000000);
    chk(prod_n, 36'h400000000);
    go(6'b111111, 18'h00001, 18'h00001);
    chk(prod, 36'h0);
    chk(36'(ch_out), 36'h0);
    // clear only the first stage
    go(6'b101000, 18'h3FFFF, 18'h3FFFF);
    go(6'b010000, 18'h00002, 18'h00002);
    chk(36'(ch_out), 36'h3FFFF);
    go(6'b000010, 18'h00002, 18'h00002);
    chk(prod, 36'h0);
    chk(prod_n, 36'h0);
    // every control inverted
    bus(1'b1, psm_pkg::ADDR_CFG, 32'h3F7);
    go(6'b010111, 18'h00002, 18'h00004);
    chk(36'(ch_out), 36'h4);
    chk(36'(ch_out_n), 36'h4);
    go(6'b010101, 18'h00009, 18'h00009);
    chk(prod, 36'h8);
    chk(prod_n, 36'h8);
    go(6'b101010, 18'h00009, 18'h00009);
    chk(prod, 36'h0);
    chk(prod_n, 36'h0);
    // nothing inserted, chain source
    nbr_d <= 18'h00009;
    bus(1'b1, psm_pkg::ADDR_CFG, 32'h008);
    go(6'b000000, 18'h3FFFF, 18'h00001);
    chk(36'(ch_out), 36'h9);
    chk(prod, mul(18'h3FFFF, 18'h00009));
    nbr_d <= 18'h3FFF0;
    @(posedge hclk);
    #1;
    chk(36'(ch_out), 36'h3FFF0);
    // product stage only, direct source
    bus(1'b1, psm_pkg::ADDR_CFG, 32'h004);
    @(posedge hclk);
    ctl <= 6'b000000;
    op_b <= 18'h00003;
    #1;
    chk(36'(ch_out), 36'h3);
    go(6'b000010, 18'h3FFFF, 18'h00003);
    chk(prod, mul(18'h3FFFF, 18'h00003));
    chk(prod_n, mul(18'h3FFFF, 18'h00003));
    // reset in mid-run brings the settings back to their reset value
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, psm_pkg::ADDR_CFG, 32'h0);
    chk(36'(rd), 36'h007);
    stop_test();
  end
endmodule : testbench
